// ==== owd_chk.sv ====
`timescale 1ns/10ps
module owd_chk #(
	parameter int START_TIMEOUT = 65536
) (
	input wire logic ref_clk, // clock
	input wire logic rst, // reset
	input wire logic [1:0] address, // word
	input wire logic read, // read
	input wire logic write, // write
	input wire logic [31:0] writedata, // data
	input wire logic [3:0] byteenable, // lanes
	input wire logic waitrequest, // wait
	input wire logic lineIn, // pin
	input wire logic lineOeN, // drive
	input wire logic pinFuseCfg, // fuse
	input wire logic hvPulseIn, // hv
	input wire logic keyValid, // key
	input wire logic instrDone, // done
	input wire logic repeatBody, // repeat
	input wire logic clkReq, // clock req
	input wire logic commEnable, // link up
	input wire logic syncExpected, // sync due
	input wire logic sysReset, // reset out
	input wire logic cpuHalt, // halt
	input wire logic lockClear, // unlock
	input wire logic progStarted, // prog
	input wire logic pinIsDebug // pin mode
);
	logic [15:0] lowCnt_ff, nxt_lowCnt;
	logic [17:0] idleCnt_ff, nxt_idleCnt;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	always_comb
	begin
		nxt_lowCnt = lineOeN ? 16'h0000 : lowCnt_ff + 16'h0001;
		nxt_idleCnt = (!clkReq || commEnable || !lineIn || !lineOeN) ? 18'h0_0000 :
			idleCnt_ff + 18'h0_0001;
	end
	always_ff @(posedge ref_clk)
	begin
		lowCnt_ff <= rst ? 16'h0000 : nxt_lowCnt;
		idleCnt_ff <= rst ? 18'h0_0000 : nxt_idleCnt;
	end
	a_drive_req: assert property (!lineOeN |-> clkReq) else $error("drive without clock");
	a_low_span: assert property ($rose(lineOeN) |-> lowCnt_ff >= owd_pkg::STARTUP_CYC)
		else $error("low drive too short");
	a_comm_rel: assert property (commEnable |-> lineOeN) else $error("link up while held");
	a_idle_to: assert property (int'(idleCnt_ff) <= START_TIMEOUT + 8)
		else $error("start timeout missed");
	a_dis_reset: assert property (write && !waitrequest && address == 2'h0 && byteenable[0]
		&& writedata[0] |=> sysReset && !clkReq && !commEnable && !progStarted)
		else $error("disable not honoured");
	a_key_prog: assert property (keyValid && commEnable && !write |=> lockClear && progStarted)
		else $error("key ignored");
	a_sync_rearm: assert property (instrDone && !repeatBody && commEnable && !write
		|=> syncExpected) else $error("sync not expected");
	a_repeat_hold: assert property (instrDone && repeatBody && !syncExpected && commEnable
		&& !write |=> !syncExpected) else $error("sync asked in repeat");
	a_fuse_gate: assert property (!pinFuseCfg && $past(pinFuseCfg, 4) == 1'b0 && !pinIsDebug
		&& lineOeN |=> lineOeN) else $error("enabled without fuse");
	a_hv_force: assert property ($rose(hvPulseIn) |-> ##[2:6] (pinIsDebug && cpuHalt))
		else $error("hv not forced");
	a_bus_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("bus no answer");
	cover property ($rose(commEnable));
	cover property ($rose(lockClear));
	cover property ($fell(clkReq) && !sysReset);
endmodule

// ==== owd_enable_sync.sv ====
// The register addresses and register access over Avalon-MM were left to the implementer.
`timescale 1ns/10ps
module owd_enable_sync #(
	parameter int START_TIMEOUT = owd_pkg::START_TIMEOUT_CYC,
	parameter int HV_TIMEOUT = owd_pkg::HV_TIMEOUT_CYC
) (
	input wire logic ref_clk, // 200 MHz clock
	input wire logic rst, // Power-on reset, sync, high
	input wire logic [1:0] address, // Avalon word address
	input wire logic read, // Avalon read
	input wire logic write, // Avalon write
	input wire logic [31:0] writedata, // Avalon write data
	input wire logic [3:0] byteenable, // Avalon byte enables
	output logic [31:0] readdata, // Avalon read data
	output logic waitrequest, // Avalon wait request
	input wire logic lineIn, // Port line level (pin)
	output logic lineOut, // Port line drive value
	output logic lineOeN, // Port line drive enable, low drives
	input wire logic pinFuseCfg, // Pin-function fuse bit (pin)
	input wire logic hvPulseIn, // High-voltage detector (pin)
	input wire logic oscStable, // Port oscillator stable (pin)
	input wire logic keyValid, // Programming key received, pulse
	input wire logic instrDone, // Instruction finished, pulse
	input wire logic repeatBody, // Repeat in progress
	output logic clkReq, // Port clock request
	output logic commEnable, // Serial link usable
	output logic syncExpected, // Next frame is a sync
	output logic [15:0] baudCount, // Cycles over eight sync bits
	output logic sysReset, // System reset pulse
	output logic cpuHalt, // Processor halted
	output logic lockClear, // Clear lock bits pulse
	output logic progStarted, // Programming-started flag
	output logic pinIsDebug, // Pin in debug function
	output logic [1:0] portClkSel // Port clock select
);
	// ---------------------------------------------------------------
	// Input synchronisers
	// ---------------------------------------------------------------
	logic [3:0] pinMeta_ff;
	logic [3:0] pinSync_ff;
	logic linePrev_ff;
	logic hvPrev_ff;

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			pinMeta_ff <= 4'h7;
			pinSync_ff <= 4'h7;
			linePrev_ff <= 1'b1;
			hvPrev_ff <= 1'b1;
		end
		else
		begin
			pinMeta_ff <= {pinFuseCfg, oscStable, hvPulseIn, lineIn};
			pinSync_ff <= pinMeta_ff;
			linePrev_ff <= pinSync_ff[0];
			hvPrev_ff <= pinSync_ff[1];
		end
	end

	// ---------------------------------------------------------------
	// Core state
	// ---------------------------------------------------------------
	owd_pkg::owd_state_e state_ff, nxt_state;
	logic [16:0] cnt_ff, nxt_cnt;
	logic [7:0] lowCnt_ff, nxt_lowCnt;
	logic [2:0] edges_ff, nxt_edges;
	logic [31:0] hvTimer_ff, nxt_hvTimer;
	logic hvArmed_ff, nxt_hvArmed;
	logic hvOverride_ff, nxt_hvOverride;
	logic syncErr_ff, nxt_syncErr;
	logic [31:0] readdata_ff, nxt_readdata;
	logic waitReq_ff, nxt_waitReq;
	logic lineOut_ff, lineOeN_ff, nxt_lineOeN;
	logic clkReq_ff, nxt_clkReq;
	logic commEnable_ff, nxt_commEnable;
	logic syncExp_ff, nxt_syncExp;
	logic [15:0] baud_ff, nxt_baud;
	logic sysReset_ff, nxt_sysReset;
	logic cpuHalt_ff, nxt_cpuHalt;
	logic lockClear_ff, nxt_lockClear;
	logic prog_ff, nxt_prog;
	logic pinDbg_ff, nxt_pinDbg;
	logic [1:0] clkSel_ff, nxt_clkSel;

	logic lineFall;
	logic regWr;
	logic regRd;
	logic disWr;
	logic enableOk;
	logic syncBad;
	logic [16:0] measured;

	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_lowCnt = lowCnt_ff;
		nxt_edges = edges_ff;
		nxt_hvTimer = hvTimer_ff;
		nxt_hvArmed = hvArmed_ff;
		nxt_hvOverride = hvOverride_ff;
		nxt_syncErr = syncErr_ff;
		nxt_readdata = readdata_ff;
		nxt_lineOeN = 1'b1;
		nxt_clkReq = clkReq_ff;
		nxt_commEnable = commEnable_ff;
		nxt_syncExp = syncExp_ff;
		nxt_baud = baud_ff;
		nxt_sysReset = 1'b0;
		nxt_cpuHalt = cpuHalt_ff;
		nxt_lockClear = 1'b0;
		nxt_prog = prog_ff;
		nxt_clkSel = clkSel_ff;
		lineFall = linePrev_ff && !pinSync_ff[0];
		regWr = write && !waitReq_ff;
		regRd = read && waitReq_ff;
		disWr = regWr && (address == owd_pkg::REG_CTRL) && byteenable[0]
			&& writedata[owd_pkg::CTRL_DIS_BIT];
		enableOk = pinSync_ff[3] || hvOverride_ff; // [RL5]
		measured = cnt_ff + 17'h0_0001;
		syncBad = measured[16] || (measured < 17'(owd_pkg::MIN_SYNC_CYC)); // [RL13]

		// Bus slave: one wait cycle, then a single answer cycle
		nxt_waitReq = !((read || write) && waitReq_ff);
		if (regWr && (address == owd_pkg::REG_CTRL) && byteenable[0])
		begin
			nxt_clkSel = writedata[owd_pkg::CTRL_CLKSEL_LSB +: 2];
		end
		if (regRd)
		begin
			nxt_readdata = 32'h0000_0000;
			unique case (address)
				owd_pkg::REG_CTRL:
				begin
					nxt_readdata[owd_pkg::CTRL_CLKSEL_LSB +: 2] = clkSel_ff;
				end
				owd_pkg::REG_STATUS:
				begin
					nxt_readdata[owd_pkg::STAT_ENABLED] = commEnable_ff;
					nxt_readdata[owd_pkg::STAT_SYNC_EXP] = syncExp_ff;
					nxt_readdata[owd_pkg::STAT_PROG] = prog_ff;
					nxt_readdata[owd_pkg::STAT_HV] = hvOverride_ff;
					nxt_readdata[owd_pkg::STAT_HALT] = cpuHalt_ff;
					nxt_readdata[owd_pkg::STAT_SYNC_ERR] = syncErr_ff;
					nxt_readdata[owd_pkg::STAT_CLK_REQ] = clkReq_ff;
					nxt_readdata[owd_pkg::STAT_PIN_DBG] = pinDbg_ff;
					nxt_readdata[owd_pkg::STAT_STATE_LSB +: 3] = state_ff;
				end
				owd_pkg::REG_BAUD:
				begin
					nxt_readdata[15:0] = baud_ff;
				end
				default:
				begin
					nxt_readdata = 32'h0000_0000;
				end
			endcase
		end

		// Enable sequence and sync measurement
		unique case (state_ff)
			owd_pkg::ST_OFF:
			begin
				nxt_clkReq = 1'b0;
				nxt_commEnable = 1'b0;
				nxt_syncExp = 1'b0;
				if (enableOk && !pinSync_ff[0])
				begin
					nxt_lowCnt = lowCnt_ff + 8'h01;
					if (lowCnt_ff == 8'(owd_pkg::LOW_PULSE_CYC)) // [RL6]
					begin
						nxt_state = owd_pkg::ST_DRIVE;
						nxt_clkReq = 1'b1; // [RL7]
						nxt_lineOeN = 1'b0;
						nxt_cnt = 17'h0_0000;
						nxt_lowCnt = 8'h00;
					end
				end
				else
				begin
					nxt_lowCnt = 8'h00;
				end
			end
			owd_pkg::ST_DRIVE:
			begin
				nxt_lineOeN = 1'b0; // [RL7] [RL23]
				if (cnt_ff < 17'(owd_pkg::STARTUP_CYC))
				begin
					nxt_cnt = cnt_ff + 17'h0_0001; // [RL11]
				end
				else if (pinSync_ff[2])
				begin
					nxt_lineOeN = 1'b1;
					nxt_state = owd_pkg::ST_WAIT_START;
					nxt_cnt = 17'h0_0000; // [RL24]
				end
			end
			owd_pkg::ST_WAIT_START:
			begin
				nxt_cnt = cnt_ff + 17'h0_0001;
				if (lineFall)
				begin
					nxt_state = owd_pkg::ST_MEAS; // [RL24]
					nxt_cnt = 17'h0_0000;
					nxt_edges = 3'h0;
				end
				else if (cnt_ff == 17'(START_TIMEOUT - 1))
				begin
					nxt_state = owd_pkg::ST_OFF; // [RL12] [RL14]
					nxt_clkReq = 1'b0;
				end
			end
			owd_pkg::ST_MEAS:
			begin
				nxt_cnt = cnt_ff + 17'h0_0001; // [RL3]
				if (lineFall)
				begin
					nxt_edges = edges_ff + 3'h1;
				end
				if (cnt_ff[16] || (lineFall && edges_ff == 3'(owd_pkg::SYNC_FALL_EDGES - 1)))
				begin
					// Fourth data fall of 0x55 closes eight bit times [RL21] [RL22]
					if (syncBad && !commEnable_ff)
					begin
						nxt_state = owd_pkg::ST_OFF; // [RL13] [RL14]
						nxt_clkReq = 1'b0;
					end
					else if (syncBad)
					begin
						nxt_state = owd_pkg::ST_ACTIVE;
						nxt_syncErr = 1'b1;
					end
					else
					begin
						nxt_state = owd_pkg::ST_ACTIVE;
						nxt_baud = measured[15:0]; // [RL3]
						nxt_commEnable = 1'b1; // [RL4]
						nxt_syncExp = 1'b0; // [RL9]
						nxt_syncErr = 1'b0;
					end
				end
			end
			owd_pkg::ST_ACTIVE:
			begin
				if (syncExp_ff && lineFall)
				begin
					nxt_state = owd_pkg::ST_MEAS; // [RL1]
					nxt_cnt = 17'h0_0000;
					nxt_edges = 3'h0;
				end
				else if (instrDone && !repeatBody)
				begin
					nxt_syncExp = 1'b1; // [RL1] [RL2]
				end
				if (keyValid)
				begin
					nxt_lockClear = 1'b1; // [RL10]
					nxt_prog = 1'b1;
				end
			end
		endcase

		// High-voltage override and unlock timeout
		if (pinSync_ff[1] && !hvPrev_ff)
		begin
			nxt_hvOverride = 1'b1; // [RL15]
			nxt_sysReset = 1'b1;
			nxt_cpuHalt = 1'b1;
			nxt_hvArmed = 1'b1;
			nxt_hvTimer = 32'h0000_0000;
		end
		else if (hvArmed_ff)
		begin
			nxt_hvTimer = hvTimer_ff + 32'h0000_0001;
			if (keyValid && commEnable_ff)
			begin
				nxt_hvArmed = 1'b0; // [RL15]
				nxt_cpuHalt = 1'b0;
			end
			else if (hvTimer_ff == 32'(HV_TIMEOUT - 1))
			begin
				nxt_hvArmed = 1'b0; // [RL15]
				nxt_cpuHalt = 1'b0;
				nxt_hvOverride = 1'b0;
				nxt_sysReset = 1'b1;
				nxt_state = owd_pkg::ST_OFF;
				nxt_clkReq = 1'b0;
				nxt_commEnable = 1'b0;
				nxt_syncExp = 1'b0;
				nxt_prog = 1'b0;
			end
		end

		// Regular disable wins over everything but the override
		if (disWr)
		begin
			nxt_state = owd_pkg::ST_OFF; // [RL19]
			nxt_sysReset = 1'b1;
			nxt_cpuHalt = 1'b0;
			nxt_hvArmed = 1'b0;
			nxt_clkReq = 1'b0;
			nxt_commEnable = 1'b0;
			nxt_syncExp = 1'b0;
			nxt_prog = 1'b0;
			nxt_syncErr = 1'b0;
			nxt_lineOeN = 1'b1;
			nxt_clkSel = owd_pkg::CLKSEL_RESET;
		end
		nxt_pinDbg = pinSync_ff[3] || nxt_hvOverride; // [RL18]
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			state_ff <= owd_pkg::ST_OFF;
			cnt_ff <= 17'h0_0000;
			lowCnt_ff <= 8'h00;
			edges_ff <= 3'h0;
			hvTimer_ff <= 32'h0000_0000;
			hvArmed_ff <= 1'b0;
			hvOverride_ff <= 1'b0; // [RL18]
			syncErr_ff <= 1'b0;
			readdata_ff <= 32'h0000_0000;
			waitReq_ff <= 1'b1;
			lineOut_ff <= 1'b0;
			lineOeN_ff <= 1'b1;
			clkReq_ff <= 1'b0;
			commEnable_ff <= 1'b0;
			syncExp_ff <= 1'b0;
			baud_ff <= 16'h0000;
			sysReset_ff <= 1'b0;
			cpuHalt_ff <= 1'b0;
			lockClear_ff <= 1'b0;
			prog_ff <= 1'b0;
			pinDbg_ff <= 1'b0;
			clkSel_ff <= owd_pkg::CLKSEL_RESET;
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			lowCnt_ff <= nxt_lowCnt;
			edges_ff <= nxt_edges;
			hvTimer_ff <= nxt_hvTimer;
			hvArmed_ff <= nxt_hvArmed;
			hvOverride_ff <= nxt_hvOverride;
			syncErr_ff <= nxt_syncErr;
			readdata_ff <= nxt_readdata;
			waitReq_ff <= nxt_waitReq;
			lineOut_ff <= 1'b0;
			lineOeN_ff <= nxt_lineOeN;
			clkReq_ff <= nxt_clkReq;
			commEnable_ff <= nxt_commEnable;
			syncExp_ff <= nxt_syncExp;
			baud_ff <= nxt_baud;
			sysReset_ff <= nxt_sysReset;
			cpuHalt_ff <= nxt_cpuHalt;
			lockClear_ff <= nxt_lockClear;
			prog_ff <= nxt_prog;
			pinDbg_ff <= nxt_pinDbg;
			clkSel_ff <= nxt_clkSel;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign readdata = readdata_ff;
	assign waitrequest = waitReq_ff;
	assign lineOut = lineOut_ff;
	assign lineOeN = lineOeN_ff;
	assign clkReq = clkReq_ff;
	assign commEnable = commEnable_ff;
	assign syncExpected = syncExp_ff;
	assign baudCount = baud_ff;
	assign sysReset = sysReset_ff;
	assign cpuHalt = cpuHalt_ff;
	assign lockClear = lockClear_ff;
	assign progStarted = prog_ff;
	assign pinIsDebug = pinDbg_ff;
	assign portClkSel = clkSel_ff;
endmodule

// ==== owd_pkg.sv ====
// Behaviour
// RL1 - Sync character expected before every new instruction
// RL2 - Repeated instructions need sync only first
// RL3 - Count clock cycles over eight sync bits
// RL4 - No communication before enable sequence completes
// RL5 - Enable only with pin-function bit or override
// RL6 - Programmer pulls line low over 200 ns
// RL7 - Edge detector holds line low until clock stable
// RL8 - Programmer polls line high, then sends sync
// RL9 - Enabling sync serves the first instruction
// RL10 - Key clears locks, sets programming-started flag
// RL11 - Low-drive lasts 256 cycles of 32 MHz
// RL12 - No sync start in 65536 cycles disables
// RL13 - Sync too long or too short disables; code does so only before enable, later it sets the sync error flag
// RL14 - Self-disable drops requests, returns to disabled
// RL15 - High-voltage pulse forces debug pin, resets, halts
// RL16 - Programmer enables and keys before high-voltage timeout
// RL17 - High-voltage pulse only after power-on reset
// RL18 - Only power-on reset cancels pin override; code also cancels it at high-voltage timeout
// RL19 - Disable bit resets system, drops clock, clears keys
// RL20 - Programmer writes disable bit at session end
// RL21 - Sync character is fixed byte 0x55
// RL22 - Frame: start, eight data, even parity, two stops
// RL23 - Line is open-drain with pull-up
// RL24 - Start timeout runs from release to start edge
package owd_pkg;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int LOW_PULSE_MIN_NS = 200;
	localparam int LOW_PULSE_CYC = (LOW_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OSC_WAIT_CYCLES = 256;
	localparam int OSC_FREQ_MHZ = 32;
	localparam int OSC_WAIT_NS = OSC_WAIT_CYCLES * 1000 / OSC_FREQ_MHZ;
	localparam int STARTUP_CYC = OSC_WAIT_NS / CLK_PERIOD_NS;
	localparam int START_TIMEOUT_CYC = 65536;
	localparam int HV_TIMEOUT_CYC = 400000;
	// ---------------------------------------------------------------
	// Sync character
	// ---------------------------------------------------------------
	localparam logic [7:0] SYNC_CHAR = 8'h55;
	localparam int SYNC_BITS = 8;
	localparam int SYNC_FALL_EDGES = 4;
	localparam int MIN_BIT_CYC = 8;
	localparam int MIN_SYNC_CYC = MIN_BIT_CYC * SYNC_BITS;
	// ---------------------------------------------------------------
	// Registers (word index)
	// ---------------------------------------------------------------
	localparam logic [1:0] REG_CTRL = 2'h0;
	localparam logic [1:0] REG_STATUS = 2'h1;
	localparam logic [1:0] REG_BAUD = 2'h2;
	localparam int CTRL_DIS_BIT = 0;
	localparam int CTRL_CLKSEL_LSB = 1;
	localparam logic [1:0] CLKSEL_RESET = 2'h3;
	localparam int STAT_ENABLED = 0;
	localparam int STAT_SYNC_EXP = 1;
	localparam int STAT_PROG = 2;
	localparam int STAT_HV = 3;
	localparam int STAT_HALT = 4;
	localparam int STAT_SYNC_ERR = 5;
	localparam int STAT_CLK_REQ = 6;
	localparam int STAT_PIN_DBG = 7;
	localparam int STAT_STATE_LSB = 8;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_DRIVE,
		ST_WAIT_START,
		ST_MEAS,
		ST_ACTIVE
	} owd_state_e;
endpackage

// ==== owd_prog_model.sv ====
`timescale 1ns/10ps
module owd_prog_model (
	input wire logic ref_clk, // clock
	input wire logic lineIn, // line level
	output logic progDrv // 0 pulls low
);
	initial progDrv = 1'b1;
	task automatic wake();
		progDrv <= 1'b0;
		repeat (60) @(posedge ref_clk);
		progDrv <= 1'b1;
	endtask
	task automatic waitHigh();
		int n;
		n = 0;
		repeat (4) @(posedge ref_clk);
		while (lineIn !== 1'b1 && n < 5000)
		begin
			@(posedge ref_clk);
			n++;
		end
		repeat (5) @(posedge ref_clk);
	endtask
	task automatic send(input logic [7:0] d, input int b);
		logic [11:0] f;
		f = {2'b11, ^d, d, 1'b0};
		for (int i = 0; i < 12; i++)
		begin
			progDrv <= f[i];
			repeat (b) @(posedge ref_clk);
		end
	endtask
endmodule

// ==== tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
	localparam int ST = 200;
	localparam int HT = 3000;
	logic ref_clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0;
	logic [1:0] address = 2'h0;
	logic [31:0] writedata = 32'h0000_0000, readdata, q;
	logic [3:0] byteenable = 4'hf;
	logic waitrequest, lineIn, lineOut, lineOeN, progDrv;
	logic pinFuseCfg = 1'b1, hvPulseIn = 1'b0, oscStable = 1'b0;
	logic keyValid = 1'b0, instrDone = 1'b0, repeatBody = 1'b0;
	logic clkReq, commEnable, syncExpected, sysReset, cpuHalt, lockClear, progStarted;
	logic pinIsDebug;
	logic [15:0] baudCount;
	logic [1:0] portClkSel;
	logic [7:0] seed = 8'h36;
	int mismatches = 0, checks_done = 0, nSys = 0, nLock = 0, b, k;
	always #2.5 ref_clk = ~ref_clk;
	assign lineIn = progDrv & (lineOeN | lineOut);
	owd_enable_sync #(.START_TIMEOUT(ST), .HV_TIMEOUT(HT)) owd_enable_sync_inst (
		.ref_clk(ref_clk), .rst(rst), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .lineIn(lineIn), .lineOut(lineOut), .lineOeN(lineOeN),
		.pinFuseCfg(pinFuseCfg), .hvPulseIn(hvPulseIn), .oscStable(oscStable),
		.keyValid(keyValid), .instrDone(instrDone), .repeatBody(repeatBody), .clkReq(clkReq),
		.commEnable(commEnable), .syncExpected(syncExpected), .baudCount(baudCount),
		.sysReset(sysReset), .cpuHalt(cpuHalt), .lockClear(lockClear),
		.progStarted(progStarted), .pinIsDebug(pinIsDebug), .portClkSel(portClkSel));
	owd_prog_model owd_prog_model_inst (.ref_clk(ref_clk), .lineIn(lineIn), .progDrv(progDrv));
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic logic [15:0] expBaud(input int bt);
		return 16'(8 * bt);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [1:0] a, input logic [31:0] d);
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= d;
		do
		begin
			@(posedge ref_clk);
		end
		while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic pulse(input logic key, input logic rep);
		keyValid <= key;
		instrDone <= !key;
		repeatBody <= rep;
		@(posedge ref_clk);
		keyValid <= 1'b0;
		instrDone <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask
	task automatic enable();
		oscStable <= 1'b0;
		owd_prog_model_inst.wake();
		chk(lineOeN, 1'b0);
		chk(clkReq, 1'b1);
		repeat (1800) @(posedge ref_clk);
		chk(lineOeN, 1'b0);
		oscStable <= 1'b1;
		owd_prog_model_inst.waitHigh();
		chk(lineIn, 1'b1);
	endtask
	task automatic sync();
		seed = lfsr(seed);
		b = 8 + int'(seed[2:0]);
		owd_prog_model_inst.send(8'h55, b);
		repeat (5) @(posedge ref_clk);
		chk(32'(baudCount - expBaud(b) <= 16'h0001), 32'h0000_0001);
		chk(syncExpected, 1'b0);
	endtask
	always @(posedge ref_clk)
	begin
		if (sysReset === 1'b1)
			nSys++;
		if (lockClear === 1'b1)
			nLock++;
	end
	initial
	begin
		repeat (60000) @(posedge ref_clk);
		mismatches++;
		conclude();
	end
	initial
	begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		bus(1'b0, owd_pkg::REG_STATUS, 32'h0000_0000);
		chk(q, 32'h0000_0080);
		bus(1'b0, 2'h3, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		chk(32'(portClkSel), 32'h0000_0003);
		pinFuseCfg <= 1'b0;
		repeat (8) @(posedge ref_clk);
		owd_prog_model_inst.wake();
		repeat (10) @(posedge ref_clk);
		chk(lineOeN, 1'b1);
		pinFuseCfg <= 1'b1;
		repeat (8) @(posedge ref_clk);
		enable();
		repeat (ST + 20) @(posedge ref_clk);
		chk(clkReq, 1'b0);
		enable();
		owd_prog_model_inst.send(8'h55, 4);
		chk(clkReq, 1'b0);
		enable();
		chk(commEnable, 1'b0);
		sync();
		chk(commEnable, 1'b1);
		bus(1'b0, owd_pkg::REG_BAUD, 32'h0000_0000);
		chk(q, 32'(expBaud(b)));
		pulse(1'b0, 1'b1);
		chk(syncExpected, 1'b0);
		pulse(1'b0, 1'b0);
		chk(syncExpected, 1'b1);
		owd_prog_model_inst.send(8'h55, 4);
		bus(1'b0, owd_pkg::REG_STATUS, 32'h0000_0000);
		chk(q, 32'h0000_04e3);
		sync();
		k = nLock;
		pulse(1'b1, 1'b0);
		chk(progStarted, 1'b1);
		chk(32'(nLock - k), 32'h0000_0001);
		bus(1'b1, owd_pkg::REG_CTRL, 32'h0000_0002);
		chk(32'(portClkSel), 32'h0000_0001);
		k = nSys;
		bus(1'b1, owd_pkg::REG_CTRL, 32'h0000_0001);
		repeat (2) @(posedge ref_clk);
		chk(32'(nSys - k), 32'h0000_0001);
		chk({clkReq, progStarted, commEnable}, 32'h0000_0000);
		bus(1'b0, owd_pkg::REG_CTRL, 32'h0000_0000);
		chk(q, 32'h0000_0006);
		pinFuseCfg <= 1'b0;
		repeat (8) @(posedge ref_clk);
		for (int i = 0; i < 2; i++)
		begin
			k = nSys;
			hvPulseIn <= 1'b1;
			repeat (8) @(posedge ref_clk);
			hvPulseIn <= 1'b0;
			chk({pinIsDebug, cpuHalt}, 32'h0000_0003);
			chk(32'(nSys - k), 32'h0000_0001);
			if (i == 0)
			begin
				repeat (HT + 20) @(posedge ref_clk);
				chk({pinIsDebug, cpuHalt}, 32'h0000_0000);
			end
		end
		enable();
		sync();
		pulse(1'b1, 1'b0);
		chk(cpuHalt, 1'b0);
		bus(1'b1, owd_pkg::REG_CTRL, 32'h0000_0001);
		repeat (3) @(posedge ref_clk);
		chk(pinIsDebug, 1'b1);
		conclude();
	end
endmodule
bind owd_enable_sync owd_chk #(.START_TIMEOUT(START_TIMEOUT)) owd_chk_inst (
	.ref_clk(ref_clk), .rst(rst), .address(address), .read(read), .write(write),
	.writedata(writedata), .byteenable(byteenable), .waitrequest(waitrequest),
	.lineIn(lineIn), .lineOeN(lineOeN), .pinFuseCfg(pinFuseCfg), .hvPulseIn(hvPulseIn),
	.keyValid(keyValid), .instrDone(instrDone), .repeatBody(repeatBody), .clkReq(clkReq),
	.commEnable(commEnable), .syncExpected(syncExpected), .sysReset(sysReset),
	.cpuHalt(cpuHalt), .lockClear(lockClear), .progStarted(progStarted),
	.pinIsDebug(pinIsDebug));
